// ---- sdl_dac_end.sv ----
// dac end: shift register, converter latch and output level
`default_nettype none

module sdl_dac_end #(
    parameter bit HAS_STROBE = 1'b1,
    parameter int DATA_W = sdl_pkg::DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link
    sdl_link_if.dac link,
    // output mode select
    input wire logic bipolar_mode,
    // latch and level
    output logic [13:0] dac_code_ff,
    output logic [13:0] level_ff,
    // status
    output logic load_pulse_ff,
    output logic word_clean_ff,
    output logic frame_short_ff,
    output logic frame_long_ff
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    generate
        if (DATA_W != 14) begin : g_bad_width
            $error("sdl_dac_end serves 14-bit words only");
        end
    endgenerate

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;
    logic [3:0] pins;
    logic [3:0] nxt_sync1;
    logic [3:0] nxt_sync2;
    logic [3:0] nxt_prev;
    logic [1:0] warm_ff;
    logic [1:0] nxt_warm;

    // gather the pins; all come from the host's domain, except the strobe lane, which is tied low when HAS_STROBE is off
    always_comb begin
        pins[sdl_pkg::PIN_SCLK] = link.sclk;
        pins[sdl_pkg::PIN_CS] = link.cs_n;
        pins[sdl_pkg::PIN_DATA] = link.serial_data_in;
        pins[sdl_pkg::PIN_STRB] = HAS_STROBE ? link.latch_load_strobe_n : 1'b0;
        nxt_sync1 = pins;
        nxt_sync2 = sync1_ff;
        nxt_prev = sync2_ff;
        // counts the edges until both edge stages hold real pin samples
        nxt_warm = (warm_ff == 2'h3) ? warm_ff : warm_ff + 2'h1;
    end

    // two stages, then one more for edge finding; only stage two reads stage one
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= sdl_pkg::PIN_IDLE;
            sync2_ff <= sdl_pkg::PIN_IDLE;
            prev_ff <= sdl_pkg::PIN_IDLE;
            warm_ff <= 2'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff <= nxt_prev;
            warm_ff <= nxt_warm;
        end
    end

    // ------------------------------------------------------------
    // edge events
    // ------------------------------------------------------------
    logic sclk_rise;
    logic cs_low;
    logic cs_rise;
    logic cs_fall;
    logic strb_low;
    logic strb_fall;
    logic shift_en;
    logic load_now;
    logic edges_ok;

    // data lane shares the clock lane's delay, so sampling stays aligned;
    // edges wait for real samples: a strobe tied low would look like a fall
    always_comb begin
        edges_ok = &warm_ff;
        sclk_rise = edges_ok & sync2_ff[sdl_pkg::PIN_SCLK] & ~prev_ff[sdl_pkg::PIN_SCLK];
        cs_low = ~sync2_ff[sdl_pkg::PIN_CS];
        cs_rise = edges_ok & sync2_ff[sdl_pkg::PIN_CS] & ~prev_ff[sdl_pkg::PIN_CS];
        cs_fall = edges_ok & ~sync2_ff[sdl_pkg::PIN_CS] & prev_ff[sdl_pkg::PIN_CS];
        strb_low = ~sync2_ff[sdl_pkg::PIN_STRB];
        strb_fall = edges_ok & ~sync2_ff[sdl_pkg::PIN_STRB] & prev_ff[sdl_pkg::PIN_STRB];
        shift_en = sclk_rise & cs_low; // RULE19 RULE20 RULE9 RULE16
        if (HAS_STROBE) begin
            // strobe tied low: select rise loads; else strobe fall while deselected
            load_now = (cs_rise & strb_low) | (strb_fall & ~cs_low); // RULE18 RULE10
        end else begin
            load_now = cs_rise; // RULE17 RULE10
        end
    end

    // ------------------------------------------------------------
    // shift register, kept without reset on purpose
    // ------------------------------------------------------------
    logic [13:0] shreg_ff;
    logic [13:0] nxt_shreg;

    // msb first: new bits enter at the bottom, oldest fall off the top
    always_comb begin
        nxt_shreg = shreg_ff;
        if (shift_en) begin
            nxt_shreg = {shreg_ff[12:0], sync2_ff[sdl_pkg::PIN_DATA]}; // RULE5 RULE6
        end
    end

    // no reset branch: power-up contents are unknown until shifted
    always_ff @(posedge clk) begin
        shreg_ff <= nxt_shreg; // RULE4
    end

    // ------------------------------------------------------------
    // defined-bit tracking and frame bit count
    // ------------------------------------------------------------
    logic [13:0] def_ff;
    logic [4:0] cnt_ff;
    logic [13:0] nxt_def;
    logic [4:0] nxt_cnt;

    // def marks which shift bits came from the link since reset
    always_comb begin
        nxt_def = def_ff;
        nxt_cnt = cnt_ff;
        if (cs_fall) begin
            nxt_cnt = sdl_pkg::CNT_RST;
        end
        if (shift_en) begin
            nxt_def = {def_ff[12:0], 1'b1};
            if (cnt_ff != sdl_pkg::CNT_MAX) begin
                nxt_cnt = cnt_ff + 5'd1; // saturates so long frames still flag
            end
        end
    end

    // tracking state
    always_ff @(posedge clk) begin
        if (rst) begin
            def_ff <= 14'h0000;
            cnt_ff <= sdl_pkg::CNT_RST;
        end else begin
            def_ff <= nxt_def;
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // converter latch and output level
    // ------------------------------------------------------------
    logic [13:0] nxt_code;
    logic [13:0] nxt_level;
    logic nxt_load;
    logic nxt_clean;
    logic nxt_short;
    logic nxt_long;

    // latch copy, status of the closing frame, and level for the mode
    always_comb begin
        nxt_code = dac_code_ff;
        nxt_clean = word_clean_ff;
        nxt_short = frame_short_ff;
        nxt_long = frame_long_ff;
        nxt_load = load_now;
        if (load_now) begin
            nxt_code = shreg_ff; // RULE17 RULE18
            nxt_clean = &def_ff; // low means unknown bits reached the latch
        end
        if (cs_rise) begin
            nxt_short = cnt_ff < 5'd14;
            nxt_long = cnt_ff > 5'd14;
        end
        if (bipolar_mode) begin
            // signed offset: step is reference over 8192, all-zero is minus reference
            nxt_level = nxt_code ^ sdl_pkg::BIP_FLIP; // RULE2
        end else begin
            // straight binary: step is reference over 16384
            nxt_level = nxt_code; // RULE1
        end
    end

    // latch resets to zero so the output starts at its low end
    always_ff @(posedge clk) begin
        if (rst) begin
            dac_code_ff <= sdl_pkg::LATCH_RST; // RULE3
            level_ff <= sdl_pkg::LATCH_RST;
            load_pulse_ff <= 1'b0;
            word_clean_ff <= 1'b1;
            frame_short_ff <= 1'b0;
            frame_long_ff <= 1'b0;
        end else begin
            dac_code_ff <= nxt_code;
            level_ff <= nxt_level;
            load_pulse_ff <= nxt_load;
            word_clean_ff <= nxt_clean;
            frame_short_ff <= nxt_short;
            frame_long_ff <= nxt_long;
        end
    end

endmodule : sdl_dac_end

`default_nettype wire

// ---- sdl_host_end.sv ----
// host end: frames a word and shifts it out msb first
`default_nettype none

module sdl_host_end #(
    parameter int FRAME_BITS = sdl_pkg::HOST_FRAME_BITS,
    parameter int HALF_CYC = sdl_pkg::SCLK_HALF_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user request
    input wire logic start,
    input wire logic [13:0] wr_data,
    input wire logic lsb_first,
    input wire logic use_strobe,
    // user status
    output logic busy_ff,
    output logic done_ff,
    // serial link
    sdl_link_if.host link
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    generate
        if (FRAME_BITS < 14 || FRAME_BITS > 63) begin : g_bad_frame
            $error("sdl_host_end frame must be 14 to 63 bits");
        end
        if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
            $error("sdl_host_end half period must be 1 to 255");
        end
    endgenerate

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b011,
        ST_DESEL = 3'b100,
        ST_STRB = 3'b101
    } sdl_hst_t;

    // lsb-first words are turned round so the msb leaves first
    function automatic logic [13:0] sdl_rev(input logic [13:0] w);
        logic [13:0] r;
        r = 14'h0000;
        for (int i = 0; i < 14; i++) begin
            r[i] = w[13 - i];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    sdl_hst_t state_ff, nxt_state;
    logic [7:0] div_ff, nxt_div;
    logic [5:0] bits_ff, nxt_bits;
    logic [FRAME_BITS-1:0] sr_ff, nxt_sr;
    logic sclk_ff, nxt_sclk;
    logic cs_n_ff, nxt_cs_n;
    logic serial_data_in_ff, nxt_serial_data_in;
    logic strb_n_ff, nxt_strb_n;
    logic strb_en_ff, nxt_strb_en;
    logic nxt_busy, nxt_done;
    logic tick;
    logic [13:0] word;

    // one step per half link period; data moves only with sclk low
    always_comb begin
        nxt_state = state_ff;
        nxt_div = div_ff;
        nxt_bits = bits_ff;
        nxt_sr = sr_ff;
        nxt_sclk = sclk_ff;
        nxt_cs_n = cs_n_ff;
        nxt_serial_data_in = serial_data_in_ff;
        nxt_strb_n = strb_n_ff;
        nxt_strb_en = strb_en_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        tick = (div_ff == 8'h00);
        word = lsb_first ? sdl_rev(wr_data) : wr_data; // RULE13
        if (!tick) begin
            nxt_div = div_ff - 8'h01;
        end
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    // filler zeros lead, data word trails
                    nxt_sr = {{(FRAME_BITS - 14){1'b0}}, word}; // RULE11 RULE8 RULE7
                    nxt_serial_data_in = nxt_sr[FRAME_BITS-1];
                    nxt_cs_n = 1'b0; // RULE12 RULE16
                    nxt_bits = 6'(FRAME_BITS);
                    nxt_div = 8'(HALF_CYC - 1);
                    nxt_strb_en = use_strobe;
                    nxt_busy = 1'b1;
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tick) begin
                    nxt_sclk = 1'b1; // RULE14 RULE9
                    nxt_div = 8'(HALF_CYC - 1);
                    nxt_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    nxt_sclk = 1'b0;
                    nxt_sr = {sr_ff[FRAME_BITS-2:0], 1'b0};
                    nxt_serial_data_in = sr_ff[FRAME_BITS-2]; // RULE15
                    nxt_bits = bits_ff - 6'd1;
                    nxt_div = 8'(HALF_CYC - 1);
                    nxt_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (tick) begin
                    nxt_div = 8'(HALF_CYC - 1);
                    if (bits_ff == 6'd0) begin
                        nxt_cs_n = 1'b1; // RULE12
                        nxt_state = ST_DESEL;
                    end else begin
                        nxt_sclk = 1'b1;
                        nxt_state = ST_HIGH;
                    end
                end
            end
            ST_DESEL: begin
                if (tick) begin
                    nxt_div = 8'(HALF_CYC - 1);
                    if (strb_en_ff) begin
                        nxt_strb_n = 1'b0; // RULE18
                        nxt_state = ST_STRB;
                    end else begin
                        nxt_busy = 1'b0;
                        nxt_done = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_STRB: begin
                if (tick) begin
                    nxt_strb_n = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // registers; strobe idles high so shifting never loads early
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            div_ff <= 8'h00;
            bits_ff <= 6'd0;
            sr_ff <= '0;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            serial_data_in_ff <= 1'b0;
            strb_n_ff <= 1'b1;
            strb_en_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            bits_ff <= nxt_bits;
            sr_ff <= nxt_sr;
            sclk_ff <= nxt_sclk;
            cs_n_ff <= nxt_cs_n;
            serial_data_in_ff <= nxt_serial_data_in;
            strb_n_ff <= nxt_strb_n;
            strb_en_ff <= nxt_strb_en;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    // link pins straight from flops
    assign link.sclk = sclk_ff;
    assign link.cs_n = cs_n_ff;
    assign link.serial_data_in = serial_data_in_ff;
    assign link.latch_load_strobe_n = strb_n_ff;

endmodule : sdl_host_end

`default_nettype wire

// ---- sdl_link_assertions.sv ----
// concurrent checks on the host-to-dac link and the dac latch
`default_nettype none

module sdl_link_assertions #(
    parameter int FRAME_BITS = 16,
    parameter int HALF_CYC = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link lines
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    input wire logic latch_load_strobe_n,
    // host status
    input wire logic busy_ff,
    input wire logic done_ff,
    // dac latch
    input wire logic bipolar_mode,
    input wire logic [13:0] dac_code_ff,
    input wire logic [13:0] level_ff,
    input wire logic load_pulse_ff
);
    // ----------------------------------------
    // frame counters
    // ----------------------------------------
    localparam logic [15:0] FRAME_CYC = 16'(2 * HALF_CYC * FRAME_BITS + HALF_CYC);
    localparam logic [15:0] FRAME_RISES = 16'(FRAME_BITS);
    logic [15:0] low_cnt_ff, nxt_low_cnt;
    logic [15:0] rise_cnt_ff, nxt_rise_cnt;
    logic sclk_d_ff, nxt_sclk_d;

    // counts restart while select is high, so each frame is judged alone
    always_comb begin
        nxt_sclk_d = sclk;
        nxt_low_cnt = cs_n ? 16'h0000 : low_cnt_ff + 16'h0001;
        nxt_rise_cnt = cs_n ? 16'h0000 : rise_cnt_ff + 16'(sclk & ~sclk_d_ff);
    end

    // registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d_ff <= 1'b0;
            low_cnt_ff <= 16'h0000;
            rise_cnt_ff <= 16'h0000;
        end else begin
            sclk_d_ff <= nxt_sclk_d;
            low_cnt_ff <= nxt_low_cnt;
            rise_cnt_ff <= nxt_rise_cnt;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("sclk not low outside frame");
    data_steady_a: assert property (sclk |-> $stable(serial_data_in))
        else $error("data moved while sclk high");
    strobe_high_a: assert property (!cs_n |-> latch_load_strobe_n)
        else $error("strobe low inside frame");
    frame_len_a: assert property ($rose(cs_n) |-> low_cnt_ff == FRAME_CYC)
        else $error("frame length wrong");
    bit_count_a: assert property ($rose(cs_n) |-> rise_cnt_ff == FRAME_RISES)
        else $error("sclk rise count wrong");
    sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("sclk high time wrong");
    code_load_a: assert property (
        !$past(rst) && dac_code_ff != $past(dac_code_ff) |-> load_pulse_ff)
        else $error("latch changed without load");
    strobe_load_a: assert property (
        $fell(latch_load_strobe_n) && cs_n |-> ##[2:5] load_pulse_ff)
        else $error("strobe fall did not load");
    load_outside_a: assert property (load_pulse_ff |-> $past(cs_n, 3))
        else $error("load inside frame");
    level_map_a: assert property (
        !$past(rst) |-> level_ff == ($past(bipolar_mode) ?
        (dac_code_ff ^ sdl_pkg::BIP_FLIP) : dac_code_ff))
        else $error("level encoding wrong");
    done_end_a: assert property (done_ff |-> !busy_ff && $past(busy_ff))
        else $error("done not at busy end");

    // main scenarios seen
    cover property (load_pulse_ff);
    cover property ($fell(latch_load_strobe_n));
    cover property (bipolar_mode && load_pulse_ff);
endmodule // sdl_link_assertions

`default_nettype wire

// ---- sdl_link_if.sv ----
// serial link between the host end and the dac end
`default_nettype none

interface sdl_link_if;
    logic sclk;
    logic cs_n;
    logic serial_data_in;
    logic latch_load_strobe_n;

    // dac end only listens
    modport dac (
        input sclk,
        input cs_n,
        input serial_data_in,
        input latch_load_strobe_n
    );

    // host end drives every line
    modport host (
        output sclk,
        output cs_n,
        output serial_data_in,
        output latch_load_strobe_n
    );
endinterface : sdl_link_if

`default_nettype wire

// ---- sdl_pkg.sv ----
// shared constants for the serial dac load path and its host
// Operation
// RULE1 - unipolar: code over 16384 of reference
// RULE2 - bipolar: code minus 8192, over 8192
// RULE3 - latch holds zero until first load
// RULE4 - shift register never cleared at power-up
// RULE5 - long frame keeps only last 14 bits
// RULE6 - short frame keeps older bits shifted along
// RULE7 - host sends 14+ bits on first write
// RULE8 - host pads narrow values with low zeros; host puts its filler zeros in the high bits, ahead of the word
// RULE9 - 14-bit words, data valid at rising clock
// RULE10 - latch updates at frame end or strobe
// RULE11 - 16-bit frames lead with two filler bits
// RULE12 - select low whole frame, then high loads
// RULE13 - msb first; reverse lsb-first words
// RULE14 - clock idles low, first-edge sampling
// RULE15 - host changes data on falling edge
// RULE16 - one select asserted; only selected accepts
// RULE17 - select rising copies shift register to latch
// RULE18 - strobe low after select rise loads latch
// RULE19 - clock edges ignored while select high
// RULE20 - shift on clock rise gated by select
`default_nettype none

package sdl_pkg;
    // ------------------------------------------------------------
    // word and scale
    // ------------------------------------------------------------
    localparam int DATA_W = 14;
    localparam int UNI_STEPS = 16384;
    localparam int BIP_STEPS = 8192;
    localparam logic [13:0] LATCH_RST = 14'h0000;
    localparam logic [13:0] BIP_FLIP = 14'h2000;
    localparam int HOST_FRAME_BITS = 16;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    // half link period in clk cycles, rounded down, at least one
    localparam int SCLK_HALF_CYC = (LINK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
        (LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));

    // ------------------------------------------------------------
    // synchroniser lanes and their idle values; frame bit counter reset and limit
    // ------------------------------------------------------------
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_DATA = 2;
    localparam int PIN_STRB = 3;
    localparam logic [3:0] PIN_IDLE = 4'b1010;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [4:0] CNT_MAX = 5'h1f;
endpackage : sdl_pkg

`default_nettype wire

// ---- tb_serial_dac_load_interface.sv ----
// bench: host end drives one dac end; a second dac end is driven by hand
`default_nettype none

module tb_serial_dac_load_interface;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [13:0] wr_data = 14'h0000;
    logic lsb_first = 1'b0;
    logic use_strobe = 1'b0;
    logic bipolar_mode = 1'b0;
    logic busy_ff, done_ff, load_a;
    logic [13:0] code_a, level_a, code_b;
    logic clean_a, short_a, long_a, clean_b, short_b, long_b;
    logic [13:0] tbl [4] = '{14'h3fff, 14'h2000, 14'h0001, 14'h0000};
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;

    sdl_link_if if_a ();
    sdl_link_if if_b ();

    sdl_host_end u_sdl_host_end (.clk(clk), .rst(rst), .start(start), .wr_data(wr_data),
        .lsb_first(lsb_first), .use_strobe(use_strobe), .busy_ff(busy_ff),
        .done_ff(done_ff), .link(if_a));
    sdl_dac_end u_sdl_dac_end (.clk(clk), .rst(rst), .link(if_a),
        .bipolar_mode(bipolar_mode), .dac_code_ff(code_a), .level_ff(level_a),
        .load_pulse_ff(load_a), .word_clean_ff(clean_a), .frame_short_ff(short_a),
        .frame_long_ff(long_a));
    // second dac end sees a bench-made link that breaks host habits on purpose
    sdl_dac_end u_sdl_dac_end_b (.clk(clk), .rst(rst), .link(if_b),
        .bipolar_mode(1'b0), .dac_code_ff(code_b), .level_ff(), .load_pulse_ff(),
        .word_clean_ff(clean_b), .frame_short_ff(short_b), .frame_long_ff(long_b));
    sdl_link_assertions #(.FRAME_BITS(sdl_pkg::HOST_FRAME_BITS),
        .HALF_CYC(sdl_pkg::SCLK_HALF_CYC)) u_sdl_link_assertions (.clk(clk), .rst(rst),
        .sclk(if_a.sclk), .cs_n(if_a.cs_n), .serial_data_in(if_a.serial_data_in),
        .latch_load_strobe_n(if_a.latch_load_strobe_n), .busy_ff(busy_ff),
        .done_ff(done_ff), .bipolar_mode(bipolar_mode), .dac_code_ff(code_a),
        .level_ff(level_a), .load_pulse_ff(load_a));

    // ----------------------------------------
    // clock, timeout and compares
    // ----------------------------------------
    always #25 clk = ~clk;

    // whole run is under two thousand cycles; this only cuts a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chkv(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chkv(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
    endtask

    function automatic logic [13:0] rev14(input logic [13:0] d);
        for (int i = 0; i < 14; i++) rev14[i] = d[13 - i];
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one host write; the wire bits are captured at each sclk rise
    task automatic host_wr(input logic [13:0] d, input logic lsb, input logic strb,
        input logic dup);
        int n;
        int nb;
        logic [15:0] cap;
        logic ps;
        int nl;
        n = 0;
        nl = 0;
        nb = 0;
        cap = 16'h0000;
        ps = 1'b0;
        start = 1'b1;
        wr_data = d;
        lsb_first = lsb;
        use_strobe = strb;
        @(negedge clk);
        start = 1'b0;
        while (done_ff !== 1'b1 && n < 400) begin
            start = dup && n == 20;
            wr_data = (dup && n == 20) ? ~d : d;
            if (if_a.sclk && !ps) begin
                cap = {cap[14:0], if_a.serial_data_in};
                nb++;
            end
            if (load_a === 1'b1) begin
                nl++;
            end
            ps = if_a.sclk;
            @(negedge clk);
            n++;
        end
        chkv("loads", {31'h0000_0000, strb}, nl);
        chk1("busy end", 1'b0, busy_ff);
        chkv("wire word", {18'h0_0000, lsb ? rev14(d) : d}, {16'h0000, cap});
        chkv("wire bits", 32'h0000_0010, nb);
        repeat (8) @(negedge clk);
        chk1("cs idle", 1'b1, if_a.cs_n);
    endtask

    // hand-made frame of n bits, msb first, strobe held low
    task automatic frame(input logic [31:0] bits, input int n);
        if_b.cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            if_b.serial_data_in = bits[i];
            repeat (4) @(negedge clk);
            if_b.sclk = 1'b1;
            repeat (4) @(negedge clk);
            if_b.sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        if_b.cs_n = 1'b1;
        if_b.serial_data_in = ~if_b.serial_data_in; // released line shows no stale bit
        repeat (10) @(negedge clk);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        if_b.sclk = 1'b0;
        if_b.cs_n = 1'b1;
        if_b.serial_data_in = 1'b0;
        if_b.latch_load_strobe_n = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chkv("code_a reset", 32'h0000_0000, {18'h0_0000, code_a});
        chk1("clean_a reset", 1'b1, clean_a);
        repeat (4) @(negedge clk);
        chkv("code_b reset", 32'h0000_0000, 32'(code_b));
        chk1("clean_b reset", 1'b1, clean_b);
        $display("test reset done");
        host_wr(14'h2abc, 1'b0, 1'b0, 1'b0);
        chkv("code_a no strobe", 32'h0000_0000, {18'h0_0000, code_a});
        chk1("long_a", 1'b1, long_a);
        chk1("short_a", 1'b0, short_a);
        host_wr(14'h2abc, 1'b0, 1'b1, 1'b0);
        chkv("code_a strobe", 32'h0000_2abc, {18'h0_0000, code_a});
        chk1("clean_a", 1'b1, clean_a);
        $display("test load done");
        for (int i = 0; i < 4; i++) begin
            bipolar_mode = 1'b1;
            host_wr(tbl[i], 1'b0, 1'b1, i == 2);
            chkv("bipolar", {18'h0_0000, tbl[i] ^ sdl_pkg::BIP_FLIP}, 32'(level_a));
            bipolar_mode = 1'b0;
            repeat (2) @(negedge clk);
            chkv("unipolar", {18'h0_0000, tbl[i]}, {18'h0_0000, level_a});
        end
        $display("test levels done");
        host_wr(14'h0123, 1'b1, 1'b1, 1'b0);
        chkv("code_a lsb", {18'h0_0000, rev14(14'h0123)}, {18'h0_0000, code_a});
        $display("test order done");
        frame(32'h0000_0155, 10);
        chk1("short_b", 1'b1, short_b);
        chk1("clean_b", 1'b0, clean_b);
        frame(32'h0000_1234, 14);
        chkv("code_b full", 32'h0000_1234, {18'h0_0000, code_b});
        chk1("clean_b full", 1'b1, clean_b);
        frame(32'h0000_0005, 4);
        chkv("code_b short", 32'h0000_2345, {18'h0_0000, code_b});
        frame(32'h000a_bcde, 20);
        chkv("code_b long", 32'h0000_3cde, {18'h0_0000, code_b});
        chk1("long_b", 1'b1, long_b);
        repeat (6) begin
            repeat (3) @(negedge clk);
            if_b.sclk = ~if_b.sclk;
            if_b.serial_data_in = ~if_b.serial_data_in;
        end
        frame(32'h0000_0000, 0);
        chkv("code_b deselected", 32'h0000_3cde, {18'h0_0000, code_b});
        $display("test frames done");
        conclude();
    end
endmodule // tb_serial_dac_load_interface

`default_nettype wire
